// file: codec_irq_pkg.sv
// package: register map, field layout and reset values of the codec interrupt block
package codec_irq_pkg;
  // ==========================================================================
  // widths
  localparam int unsigned REG_W     = 16;
  localparam int unsigned ADDR_W    = 12;
  // ==========================================================================
  // register byte offsets
  localparam logic [11:0] OFS_IRQ_ENABLE  = 12'h000;
  localparam logic [11:0] OFS_PEND_CLEAR  = 12'h004;
  localparam logic [11:0] OFS_FIFO_TRIG   = 12'h008;
  localparam logic [11:0] OFS_DMA_REQ     = 12'h00c;
  // ==========================================================================
  // reset values
  localparam logic [15:0] IRQ_ENABLE_RST  = 16'h0000;
  localparam logic [15:0] FIFO_TRIG_RST   = 16'h0000;
  // ==========================================================================
  // interrupt enable / pending bit positions
  localparam int unsigned B_ADC1_FIFO  = 0;
  localparam int unsigned B_ADC2_FIFO  = 1;
  localparam int unsigned B_LEFT_FIFO  = 2;
  localparam int unsigned B_RIGHT_FIFO = 3;
  localparam int unsigned B_ADC1_UP    = 4;
  localparam int unsigned B_ADC2_UP    = 5;
  localparam int unsigned B_DAC_UP     = 6;
  localparam int unsigned B_ADC1_DOWN  = 7;
  localparam int unsigned B_ADC2_DOWN  = 8;
  localparam int unsigned B_DAC_DOWN   = 9;
  localparam int unsigned B_ZX_LEFT    = 10;
  localparam int unsigned B_ZX_RIGHT   = 11;
  localparam int unsigned B_MIC_CLIP   = 12;
  localparam int unsigned B_ST_CLIP    = 13;
  localparam int unsigned N_SRC        = 14;
  // implemented bits; upper two are reserved and read zero
  localparam logic [15:0] IRQ_MASK     = 16'h3fff;
  // ==========================================================================
  // fifo trigger control field layout
  localparam int unsigned F_ADC1_TRIG_LSB = 0;
  localparam int unsigned F_ADC2_TRIG_LSB = 4;
  localparam int unsigned F_DAC_TRIG_LSB  = 8;
  localparam int unsigned TRIG_W          = 4;
  localparam int unsigned F_DMA_ADC1      = 12;
  localparam int unsigned F_DMA_ADC2      = 13;
  localparam int unsigned F_DMA_LEFT      = 14;
  localparam int unsigned F_DMA_RIGHT     = 15;
  // fifo channel count
  localparam int unsigned N_FIFO          = 4;
  // apb error code
  localparam logic        SLV_OK          = 1'b0;
  localparam logic        SLV_ERR         = 1'b1;
endpackage

// file: pend_if.sv
// interface: pending/clear register cell signals between the top and the cell bank
`timescale 1ns/1ps
interface pend_if #(
  parameter int unsigned N = 14
);
  logic         clk_en;
  logic [N-1:0] enable;
  logic [N-1:0] event_raw;
  logic [N-1:0] clear;
  logic [N-1:0] pending;
  modport ctrl (output clk_en, output enable, output event_raw, output clear, input pending);
  modport bank (input clk_en, input enable, input event_raw, input clear, output pending);
endinterface

// file: pend_bank.sv
// module: bank of sticky pending flags, one per interrupt source
`timescale 1ns/1ps
module pend_bank #(
  parameter int unsigned N = 14
) (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  pend_if.bank      pb
);
  // ==========================================================================
  // one sticky flag per source; set and write-one clear wait for the block clock enable, a disabled source clears without it
  // flags gather on a net so each bit has its own driver and the vector has one
  wire logic [N-1:0] pend_w;
  for (genvar i = 0; i < N; i++) begin : g_cell
    logic pend_q;
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        pend_q <= 1'b0;
      end else if (!pb.enable[i]) begin
        pend_q <= 1'b0; // disabled source stops reading pending from the next clock
      end else if (pb.clk_en) begin
        // set beats a simultaneous write-one clear, so no event is lost
        if (pb.event_raw[i]) begin
          pend_q <= 1'b1;
        end else if (pb.clear[i]) begin
          pend_q <= 1'b0;
        end
      end
    end
    assign pend_w[i] = pend_q;
  end
  assign pb.pending = pend_w;
endmodule

// file: audio_codec_irq_enable.sv
// module: codec interrupt enable, pending/clear, fifo trigger and dma gating over apb
// ============================================================================
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module audio_codec_irq_enable #(
  parameter int unsigned FIFO_CNT_W = 5
) (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  // apb slave
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [11:0]           paddr_i,
  input  wire logic [31:0]           pwdata_i,
  input  wire logic [3:0]            pstrb_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  // fifo status: order first adc, second adc, left dac, right dac
  input  wire logic [3:0]            fifo_full_i,
  input  wire logic [3:0]            fifo_empty_i,
  input  wire logic [4*FIFO_CNT_W-1:0] fifo_empty_words_i,
  input  wire logic [4*FIFO_CNT_W-1:0] fifo_valid_words_i,
  // converter and signal path events, one-cycle pulses
  input  wire logic                  first_adc_up_i,
  input  wire logic                  second_adc_up_i,
  input  wire logic                  dac_up_i,
  input  wire logic                  first_adc_down_i,
  input  wire logic                  second_adc_down_i,
  input  wire logic                  dac_down_i,
  input  wire logic                  left_zero_cross_i,
  input  wire logic                  right_zero_cross_i,
  input  wire logic                  first_digital_microphone_clip_i,
  input  wire logic                  sidetone_left_clip_i,
  input  wire logic                  sidetone_right_clip_i,
  // outputs toward cpu interrupt controller and dma controller
  output logic                       codec_irq_o,
  output logic      [3:0]            dma_req_o,
  output logic                       pend_clk_en_o
);
  localparam int unsigned NS = codec_irq_pkg::N_SRC;
  localparam int unsigned NF = codec_irq_pkg::N_FIFO;
  localparam int unsigned TW = codec_irq_pkg::TRIG_W;

  logic [15:0]  codec_irq_enable_q;
  logic [15:0]  codec_fifo_trigger_ctrl_q;
  logic [NS-1:0] src_event;
  logic [NF-1:0] fifo_trig;
  logic [NF-1:0] fifo_irq_en;
  logic [NF-1:0] fifo_dma_en;
  logic [NF-1:0] dma_d;
  logic [15:0]  pend_rd;
  logic [15:0]  wr_lane;
  logic         apb_setup;
  logic         apb_write;
  logic         addr_hit;
  logic [31:0]  rdata_d;

  pend_if #(.N(NS)) pif ();

  // ==========================================================================
  // apb decode: zero wait states, answer in the access phase
  assign apb_setup = psel_i & ~penable_i;
  assign apb_write = psel_i & penable_i & pwrite_i;
  assign pready_o  = 1'b1;
  assign addr_hit  = (paddr_i == codec_irq_pkg::OFS_IRQ_ENABLE) |
                     (paddr_i == codec_irq_pkg::OFS_PEND_CLEAR) |
                     (paddr_i == codec_irq_pkg::OFS_FIFO_TRIG)  |
                     (paddr_i == codec_irq_pkg::OFS_DMA_REQ);
  // byte lanes of the 16-bit registers follow pstrb
  assign wr_lane   = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};

  // unmapped access answers with slave error during the access phase
  always_comb begin
    pslverr_o = codec_irq_pkg::SLV_OK;
    if (psel_i && penable_i && !addr_hit) begin
      pslverr_o = codec_irq_pkg::SLV_ERR;
    end
  end

  // ==========================================================================
  // enable register; reserved bits never store
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      codec_irq_enable_q <= codec_irq_pkg::IRQ_ENABLE_RST;
    end else if (apb_write && paddr_i == codec_irq_pkg::OFS_IRQ_ENABLE) begin
      codec_irq_enable_q <= ((pwdata_i[15:0] & wr_lane) | (codec_irq_enable_q & ~wr_lane))
                            & codec_irq_pkg::IRQ_MASK;
    end
  end

  // ==========================================================================
  // fifo trigger levels and dma request enables
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      codec_fifo_trigger_ctrl_q <= codec_irq_pkg::FIFO_TRIG_RST;
    end else if (apb_write && paddr_i == codec_irq_pkg::OFS_FIFO_TRIG) begin
      codec_fifo_trigger_ctrl_q <= (pwdata_i[15:0] & wr_lane) | (codec_fifo_trigger_ctrl_q & ~wr_lane);
    end
  end

  // ==========================================================================
  // per-fifo trigger event: adcs fire on empty-word count, dac on valid-word count
  for (genvar f = 0; f < NF; f++) begin : g_fifo
    logic [TW-1:0]         lvl;
    logic [FIFO_CNT_W-1:0] words;
    if (f < 2) begin : g_adc
      assign lvl   = codec_fifo_trigger_ctrl_q[(f == 0 ? codec_irq_pkg::F_ADC1_TRIG_LSB
                                                       : codec_irq_pkg::F_ADC2_TRIG_LSB) +: TW];
      assign words = fifo_empty_words_i[f*FIFO_CNT_W +: FIFO_CNT_W];
    end else begin : g_dac
      assign lvl   = codec_fifo_trigger_ctrl_q[codec_irq_pkg::F_DAC_TRIG_LSB +: TW];
      assign words = fifo_valid_words_i[f*FIFO_CNT_W +: FIFO_CNT_W];
    end
    // level match, full or empty all raise the fifo source
    assign fifo_trig[f] = (words == FIFO_CNT_W'(lvl)) | fifo_full_i[f] | fifo_empty_i[f];
    assign fifo_irq_en[f] = codec_irq_enable_q[codec_irq_pkg::B_ADC1_FIFO + f];
    assign fifo_dma_en[f] = codec_fifo_trigger_ctrl_q[codec_irq_pkg::F_DMA_ADC1 + f];
    // interrupt enable overrides dma enable; the two never both request
    assign dma_d[f] = fifo_dma_en[f] & ~fifo_irq_en[f] & fifo_trig[f];
  end

  // ==========================================================================
  // registered dma request outputs
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      dma_req_o <= '0;
    end else begin
      dma_req_o <= dma_d;
    end
  end

  // ==========================================================================
  // source vector in pending bit order
  always_comb begin
    src_event = '0;
    src_event[codec_irq_pkg::B_ADC1_FIFO]  = fifo_trig[0];
    src_event[codec_irq_pkg::B_ADC2_FIFO]  = fifo_trig[1];
    src_event[codec_irq_pkg::B_LEFT_FIFO]  = fifo_trig[2];
    src_event[codec_irq_pkg::B_RIGHT_FIFO] = fifo_trig[3];
    src_event[codec_irq_pkg::B_ADC1_UP]    = first_adc_up_i;
    src_event[codec_irq_pkg::B_ADC2_UP]    = second_adc_up_i;
    src_event[codec_irq_pkg::B_DAC_UP]     = dac_up_i;
    src_event[codec_irq_pkg::B_ADC1_DOWN]  = first_adc_down_i;
    src_event[codec_irq_pkg::B_ADC2_DOWN]  = second_adc_down_i;
    src_event[codec_irq_pkg::B_DAC_DOWN]   = dac_down_i;
    src_event[codec_irq_pkg::B_ZX_LEFT]    = left_zero_cross_i;
    src_event[codec_irq_pkg::B_ZX_RIGHT]   = right_zero_cross_i;
    src_event[codec_irq_pkg::B_MIC_CLIP]   = first_digital_microphone_clip_i;
    src_event[codec_irq_pkg::B_ST_CLIP]    = sidetone_left_clip_i | sidetone_right_clip_i;
  end

  // ==========================================================================
  // hookup of the pending bank
  assign pif.enable    = codec_irq_enable_q[NS-1:0];
  assign pif.event_raw = src_event;
  assign pif.clk_en    = |codec_irq_enable_q;
  // write one clears, write zero leaves the flag alone
  assign pif.clear     = (apb_write && paddr_i == codec_irq_pkg::OFS_PEND_CLEAR)
                         ? (pwdata_i[NS-1:0] & wr_lane[NS-1:0]) : '0;

  pend_bank #(.N(NS)) u_pend (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .pb     (pif.bank)
  );

  assign pend_rd = {2'b00, pif.pending};

  // ==========================================================================
  // interrupt line and clock-enable status, registered
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      codec_irq_o   <= 1'b0;
      pend_clk_en_o <= 1'b0;
    end else begin
      codec_irq_o   <= |pif.pending;
      pend_clk_en_o <= |codec_irq_enable_q;
    end
  end

  // ==========================================================================
  // read mux, captured in setup so data stands through the access phase
  always_comb begin
    rdata_d = '0;
    case (paddr_i)
      codec_irq_pkg::OFS_IRQ_ENABLE: rdata_d = {16'h0000, codec_irq_enable_q};
      codec_irq_pkg::OFS_PEND_CLEAR: rdata_d = {16'h0000, pend_rd};
      codec_irq_pkg::OFS_FIFO_TRIG:  rdata_d = {16'h0000, codec_fifo_trigger_ctrl_q};
      codec_irq_pkg::OFS_DMA_REQ:    rdata_d = {28'h0000000, dma_req_o};
      default:                       rdata_d = '0;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= '0;
    end else if (apb_setup && !pwrite_i) begin
      prdata_o <= rdata_d;
    end
  end
endmodule

// file: audio_codec_irq_enable_props.sv
// checker: port-level timing relations of the codec interrupt block
`timescale 1ns/1ps
module audio_codec_irq_enable_props (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  input  wire logic [31:0] prdata_o,
  input  wire logic        first_adc_up_i,
  input  wire logic        left_zero_cross_i,
  input  wire logic        codec_irq_o,
  input  wire logic [3:0]  dma_req_o,
  input  wire logic        pend_clk_en_o
);
  logic [15:0] en_q;
  // ==========================================================================
  // shadow of the enable register; reserved bits are never stored
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) en_q <= 16'h0000;
    else if (psel_i && penable_i && pwrite_i && paddr_i == 12'h000)
      en_q <= {pstrb_i[1] ? pwdata_i[15:8] & 8'h3f : en_q[15:8], pstrb_i[0] ? pwdata_i[7:0] : en_q[7:0]};
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_up; en_q[4] && first_adc_up_i; endsequence
  sequence s_zx; en_q[10] && left_zero_cross_i; endsequence
  // the enable is given one cycle to settle, since the request is registered
  property p_mask(int i); en_q[i] && $past(en_q[i]) |-> !dma_req_o[i]; endproperty
  // look from the second reset edge on: the first may still show power-up unknowns
  a_rst_quiet: assert property (disable iff (1'b0) rst_i [*2] |->
    !codec_irq_o && dma_req_o == 4'h0 && !pend_clk_en_o)
    else $error("outputs active during reset");
  a_gate_any_en: assert property ($past(en_q) == en_q |-> pend_clk_en_o == (en_q != 16'h0000))
    else $error("pending clock gate does not follow enables");
  a_read_enable: assert property (psel_i && penable_i && !pwrite_i && paddr_i == 12'h000 |-> prdata_o == {16'h0, en_q})
    else $error("enable read back wrong");
  a_quiet_off: assert property ((en_q == 16'h0000) [*3] |-> !codec_irq_o)
    else $error("interrupt with no enable set");
  a_mask_adc1: assert property (p_mask(0))
    else $error("first adc dma not masked");
  a_mask_adc2: assert property (p_mask(1))
    else $error("second adc dma not masked");
  a_mask_left: assert property (p_mask(2))
    else $error("left dac dma not masked");
  a_mask_right: assert property (p_mask(3))
    else $error("right dac dma not masked");
  a_up_irq: assert property (s_up |-> ##[1:2] codec_irq_o)
    else $error("power-up event gave no interrupt");
  a_zx_irq: assert property (s_zx |-> ##[1:2] codec_irq_o)
    else $error("zero-crossing event gave no interrupt");
endmodule
bind audio_codec_irq_enable audio_codec_irq_enable_props u_props (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
  .prdata_o(prdata_o), .first_adc_up_i(first_adc_up_i), .left_zero_cross_i(left_zero_cross_i),
  .codec_irq_o(codec_irq_o), .dma_req_o(dma_req_o), .pend_clk_en_o(pend_clk_en_o));

// file: irq_dma_sink.sv
// partner: interrupt and dma controllers, counting the requests they take
`timescale 1ns/1ps
module irq_dma_sink (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       irq_i,
  input  wire logic [3:0] dma_i,
  output int              irq_cnt_o,
  output int              dma_cnt_o
);
  logic       irq_q;
  logic [3:0] dma_q;
  // level requests are taken once, on their rising edge, like an edge-latching controller
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
      dma_q <= 4'h0;
      irq_cnt_o <= 0;
      dma_cnt_o <= 0;
    end else begin
      irq_q <= irq_i;
      dma_q <= dma_i;
      irq_cnt_o <= irq_cnt_o + int'(irq_i && !irq_q);
      dma_cnt_o <= dma_cnt_o + $countones(dma_i & ~dma_q);
    end
  end
endmodule

// file: audio_codec_irq_enable_test.sv
// testbench: enable, pending, fifo and dma behaviour of the codec interrupt block
`timescale 1ns/1ps
module audio_codec_irq_enable_test;
  logic        mclk_i = 1'b0;
  logic        rst_i  = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq, clk_en, er;
  logic [11:0] paddr  = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h24a25d21;
  logic [3:0]  full = 4'h0, empty = 4'h0, dma;
  logic [19:0] ewords = 20'hfffff, vwords = 20'hfffff;
  logic [10:0] ev = 11'h0;
  logic [15:0] en, m;
  int          n_errors = 0, cmp_count = 0, cyc = 0, irq_cnt, dma_cnt, dexp = 0, b;

  audio_codec_irq_enable #(.FIFO_CNT_W(5)) u_audio_codec_irq_enable (
    .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .fifo_full_i(full), .fifo_empty_i(empty), .fifo_empty_words_i(ewords),
    .fifo_valid_words_i(vwords), .first_adc_up_i(ev[0]), .second_adc_up_i(ev[1]), .dac_up_i(ev[2]),
    .first_adc_down_i(ev[3]), .second_adc_down_i(ev[4]), .dac_down_i(ev[5]), .left_zero_cross_i(ev[6]),
    .right_zero_cross_i(ev[7]), .first_digital_microphone_clip_i(ev[8]), .sidetone_left_clip_i(ev[9]),
    .sidetone_right_clip_i(ev[10]), .codec_irq_o(irq), .dma_req_o(dma), .pend_clk_en_o(clk_en));
  irq_dma_sink u_irq_dma_sink (.mclk_i(mclk_i), .rst_i(rst_i), .irq_i(irq), .dma_i(dma),
    .irq_cnt_o(irq_cnt), .dma_cnt_o(dma_cnt));

  initial forever #12.5 mclk_i = ~mclk_i;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer; the request stands until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge mclk_i);
    penable <= 1'b1;
    do @(posedge mclk_i); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task stop_test;
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard: the whole run needs well under two thousand cycles
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      stop_test;
    end
  end

  initial begin
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    apb(0, 12'h000, 0);
    cmp("enable reset", 0, rd);
    cmp("gate reset", 0, clk_en);
    $display("test reset done");
    // random enables plus the reserved-only corner
    for (int i = 0; i < 6; i++) begin
      en = (i == 0) ? 16'hc000 : xs();
      apb(1, 12'h000, en);
      apb(0, 12'h000, 0);
      cmp("enable read", en & 16'h3fff, rd);
      cmp("clock gate", (en & 16'h3fff) != 0, clk_en);
    end
    $display("test enable done");
    // each event alone: set, survives write-0, cleared by write-1, ignored when disabled
    for (int k = 0; k < 11; k++) begin
      b = 4 + ((k > 9) ? 9 : k);
      for (int p = 0; p < 2; p++) begin
        apb(1, 12'h000, p ? 16'h3fff ^ (1 << b) : 1 << b);
        ev <= 11'h1 << k;
        wt(1);
        ev <= 11'h0;
        wt(3);
        if (p == 0) cmp("irq raised", 1, irq);
        apb(1, 12'h004, 0);
        apb(0, 12'h004, 0);
        cmp("pending", p ? 0 : 1 << b, rd);
        apb(1, 12'h004, 1 << b);
        apb(0, 12'h004, 0);
        cmp("pending cleared", 0, rd);
      end
    end
    cmp("irq requests", 11, irq_cnt);
    $display("test events done");
    // fifo full, empty and level match; an irq enable takes the dma request away
    apb(1, 12'h008, 32'hf555);
    for (int c = 0; c < 3; c++) begin
      m = (c == 0) ? 16'h5 : (c == 1) ? 16'ha : xs() & 16'hf;
      apb(1, 12'h000, m);
      full <= (c == 0) ? 4'hf : 4'h0;
      empty <= (c == 1) ? 4'hf : 4'h0;
      {ewords, vwords} <= (c == 2) ? {8{5'd5}} : 40'hffffffffff;
      wt(3);
      dexp += $countones(~m[3:0]);
      cmp("dma request", ~m & 16'hf, dma);
      cmp("fifo irq", m != 0, irq);
      apb(0, 12'h004, 0);
      cmp("fifo pending", m, rd);
      apb(0, 12'h00c, 0);
      cmp("dma status", ~m & 16'hf, rd);
      {full, empty, ewords, vwords} <= {8'h0, 40'hffffffffff};
      wt(3);
      apb(1, 12'h004, 32'hf);
    end
    cmp("dma requests", dexp, dma_cnt);
    $display("test fifo done");
    // unmapped place: error, reads zero, enable untouched
    apb(1, 12'h010, 32'h1);
    cmp("write error", 1, er);
    apb(0, 12'h010, 0);
    cmp("read error", 1, er);
    cmp("unmapped read", 0, rd);
    apb(0, 12'h000, 0);
    cmp("enable kept", m, rd);
    $display("test unmapped done");
    stop_test;
  end
endmodule
